// ===== core/wwd_pkg.sv
// Package of the windowed watchdog: register map, field layout and timing constants.
// Assumes a 20 MHz system clock and a Wishbone classic slave with 32-bit data.
package wwd_pkg;
	// Register byte offsets.
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_RESET_CAUSE = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam logic [3:0] ADDR_MASK = 4'hc;
	// Control register fields.
	localparam int CTRL_POST_LO = 0;
	localparam int CTRL_PRE_BIT = 4;
	localparam int CTRL_WINDOW_DISABLE_BIT = 6;
	localparam int CTRL_CFGEN_BIT = 7;
	// Reset cause register fields.
	localparam int RC_IDLE_BIT = 2;
	localparam int RC_SLEEP_BIT = 3;
	localparam int RC_TIMEOUT_BIT = 4;
	localparam int RC_SOFTEN_BIT = 5;
	// Event status bits: time-out, early clear, wake-up.
	localparam int EV_TIMEOUT = 0;
	localparam int EV_EARLY = 1;
	localparam int EV_WAKE = 2;
	localparam int EV_W = 3;
	// Configuration word reset value: config enable off, window off, 1:1, divide by 32.
	localparam logic [7:0] CTRL_RESET = 8'h40;
	// Time base: nominal low-power clock 32 kHz from a 20 MHz system clock.
	localparam int SYS_CLK_HZ = 20000000;
	localparam int LOW_POWER_RC_CLOCK_HZ = 32000;
	localparam int LOW_POWER_RC_CLOCK_DIV = SYS_CLK_HZ / (2 * LOW_POWER_RC_CLOCK_HZ) * 2;
	localparam int PRE_SHORT = 32;
	localparam int PRE_LONG = 128;
	localparam int POST_SEL_W = 4;
	localparam int POST_MAX_LOG2 = 15;
	typedef enum logic [1:0] {
		WWD_RUN = 2'b00,
		WWD_SAVE = 2'b01,
		WWD_WAKE = 2'b11
	} wwd_mode_e;
	typedef struct packed {
		logic [9:0] low_power_rc_clock_cnt;
		logic [6:0] pre_cnt;
		logic [POST_MAX_LOG2-1:0] post_cnt;
		logic [7:0] ctrl;
		logic soft_en;
		logic timeout_flag;
		logic sleep_flag;
		logic idle_flag;
		logic [EV_W-1:0] status;
		logic [EV_W-1:0] mask;
		wwd_mode_e mode;
		logic save_is_idle;
		logic ack;
		logic [31:0] rdata;
		logic wdt_reset;
		logic wake;
	} wwd_state_s;
endpackage

// ===== core/wwd_watchdog.sv
// Windowed watchdog timer with a Wishbone classic register slave.
// Assumes the core signals power-save entry, exit and clock-switch completion as pulses.
// Summary of operation
// - Enabled watchdog also enables low-power clock.
// - Prescaler divides by 32 or 128.
// - Base time-out 1 ms or 4 ms.
// - Postscaler picks one of sixteen ratios.
// - Device reset and clock switch clear counts.
// - Power-save entry and exit clear counts.
// - Clear instruction resets all counts.
// - Watchdog keeps counting in sleep, idle.
// - Time-out in power save wakes core.
// - Config enable forces watchdog always on.
// - Time-out flag sticky until software clears.
// - Otherwise soft enable bit runs watchdog.
// - Device reset clears soft enable bit.
// - Early windowed clear causes watchdog reset.
//
// The Wishbone interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module wwd_watchdog (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic reset_n,
	// Core events.
	input wire logic watchdog_clear_instr,
	input wire logic power_save_instr,
	input wire logic power_save_idle,
	input wire logic power_save_exit,
	input wire logic clock_switch_done,
	// Wishbone classic slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Outputs.
	output logic low_power_rc_clock_en,
	output logic watchdog_reset,
	output logic watchdog_wake,
	output logic irq
);
	wwd_pkg::wwd_state_s s_q;
	wwd_pkg::wwd_state_s s_d;

	// Postscaler terminal count for a 4-bit select: ratio is two to the select.
	function automatic logic post_done(input logic [wwd_pkg::POST_MAX_LOG2-1:0] cnt,
			input logic [wwd_pkg::POST_SEL_W-1:0] sel);
		logic [wwd_pkg::POST_MAX_LOG2:0] lim;
		lim = (wwd_pkg::POST_MAX_LOG2+1)'(1) << sel;
		post_done = ({1'b0, cnt} == lim - 1'b1);
	endfunction

	// Whole-period position in final quarter: top two bits of the count set.
	function automatic logic in_window(input logic [wwd_pkg::POST_MAX_LOG2-1:0] cnt,
			input logic [6:0] pre, input logic pre_long,
			input logic [wwd_pkg::POST_SEL_W-1:0] sel);
		logic [21:0] pos;
		logic [21:0] per;
		pos = pre_long ? {cnt, pre} : {2'b00, cnt, pre[4:0]};
		per = pre_long ? (22'(wwd_pkg::PRE_LONG) << sel) : (22'(wwd_pkg::PRE_SHORT) << sel);
		in_window = (pos >= per - (per >> 2));
	endfunction

	logic wdt_on;
	logic low_power_rc_clock_tick;
	logic pre_tick;
	logic clr_counts;
	logic bus_req;
	logic [3:0] adr;
	logic [wwd_pkg::EV_W-1:0] ev_set;
	logic status_rd;

	always_comb begin
		s_d = s_q;
		s_d.wdt_reset = 1'b0;
		s_d.wake = 1'b0;
		s_d.ack = 1'b0;
		ev_set = {wwd_pkg::EV_W{1'b0}};
		status_rd = 1'b0;
		adr = wb_adr_i;
		bus_req = wb_cyc_i && wb_stb_i && !s_q.ack;
		wdt_on = s_q.ctrl[wwd_pkg::CTRL_CFGEN_BIT] || s_q.soft_en;
		// The low-power clock is modelled as an enable derived from the system clock.
		low_power_rc_clock_tick = wdt_on && (s_q.low_power_rc_clock_cnt == 10'(wwd_pkg::LOW_POWER_RC_CLOCK_DIV - 1));
		pre_tick = low_power_rc_clock_tick && (s_q.ctrl[wwd_pkg::CTRL_PRE_BIT] ?
			(s_q.pre_cnt == 7'(wwd_pkg::PRE_LONG - 1)) :
			(s_q.pre_cnt[4:0] == 5'(wwd_pkg::PRE_SHORT - 1)));
		clr_counts = 1'b0;
		// Running counters; they keep going in sleep and idle.
		if (wdt_on) begin
			s_d.low_power_rc_clock_cnt = low_power_rc_clock_tick ? 10'h000 : s_q.low_power_rc_clock_cnt + 10'h001;
			if (low_power_rc_clock_tick) begin
				s_d.pre_cnt = pre_tick ? 7'h00 : s_q.pre_cnt + 7'h01;
			end
			if (pre_tick) begin
				if (post_done(s_q.post_cnt,
						s_q.ctrl[wwd_pkg::CTRL_POST_LO +: wwd_pkg::POST_SEL_W])) begin
					clr_counts = 1'b1;
					ev_set[wwd_pkg::EV_TIMEOUT] = 1'b1;
					if (s_q.mode == wwd_pkg::WWD_SAVE) begin
						s_d.wake = 1'b1;
						s_d.mode = wwd_pkg::WWD_WAKE;
						ev_set[wwd_pkg::EV_WAKE] = 1'b1;
					end else begin
						s_d.wdt_reset = 1'b1;
						s_d.timeout_flag = 1'b1;
					end
				end else begin
					s_d.post_cnt = s_q.post_cnt + 15'h0001;
				end
			end
		end else begin
			clr_counts = 1'b1;
		end
		// Clear instruction outside power save, with early-clear check in window mode.
		if (watchdog_clear_instr && s_q.mode != wwd_pkg::WWD_SAVE) begin
			clr_counts = 1'b1;
			if (wdt_on && !s_q.ctrl[wwd_pkg::CTRL_WINDOW_DISABLE_BIT] &&
					!in_window(s_q.post_cnt, s_q.pre_cnt, s_q.ctrl[wwd_pkg::CTRL_PRE_BIT],
					s_q.ctrl[wwd_pkg::CTRL_POST_LO +: wwd_pkg::POST_SEL_W])) begin
				s_d.wdt_reset = 1'b1;
				s_d.timeout_flag = 1'b1;
				ev_set[wwd_pkg::EV_EARLY] = 1'b1;
			end
		end
		// Power-save entry and exit.
		if (power_save_instr) begin
			clr_counts = 1'b1;
			s_d.mode = wwd_pkg::WWD_SAVE;
			s_d.save_is_idle = power_save_idle;
			if (power_save_idle) begin
				s_d.idle_flag = 1'b1;
			end else begin
				s_d.sleep_flag = 1'b1;
			end
		end else if (power_save_exit && s_q.mode != wwd_pkg::WWD_RUN) begin
			clr_counts = 1'b1;
			s_d.mode = wwd_pkg::WWD_RUN;
		end
		if (clock_switch_done) begin
			clr_counts = 1'b1;
		end
		// Register bus; hardware sets win over software clears.
		s_d.rdata = 32'h0000_0000;
		if (bus_req) begin
			s_d.ack = 1'b1;
			if (wb_we_i && wb_sel_i[0]) begin
				case (adr)
					wwd_pkg::ADDR_CTRL: begin
						// Once the config enable is set, only a device reset clears it.
						s_d.ctrl = wb_dat_i[7:0] |
							(s_q.ctrl & (8'h01 << wwd_pkg::CTRL_CFGEN_BIT));
					end
					wwd_pkg::ADDR_RESET_CAUSE: begin
						s_d.soft_en = wb_dat_i[wwd_pkg::RC_SOFTEN_BIT];
						s_d.timeout_flag = (wb_dat_i[wwd_pkg::RC_TIMEOUT_BIT] ||
							s_d.timeout_flag) && !(!wb_dat_i[wwd_pkg::RC_TIMEOUT_BIT] &&
							!s_d.wdt_reset);
						s_d.sleep_flag = wb_dat_i[wwd_pkg::RC_SLEEP_BIT] ||
							(power_save_instr && !power_save_idle);
						s_d.idle_flag = wb_dat_i[wwd_pkg::RC_IDLE_BIT] ||
							(power_save_instr && power_save_idle);
					end
					wwd_pkg::ADDR_MASK: begin
						s_d.mask = wb_dat_i[wwd_pkg::EV_W-1:0];
					end
					default: begin
					end
				endcase
			end else if (!wb_we_i) begin
				case (adr)
					wwd_pkg::ADDR_CTRL: s_d.rdata = {24'h000000, s_q.ctrl};
					wwd_pkg::ADDR_RESET_CAUSE: begin
						s_d.rdata[wwd_pkg::RC_SOFTEN_BIT] = s_q.soft_en;
						s_d.rdata[wwd_pkg::RC_TIMEOUT_BIT] = s_q.timeout_flag;
						s_d.rdata[wwd_pkg::RC_SLEEP_BIT] = s_q.sleep_flag;
						s_d.rdata[wwd_pkg::RC_IDLE_BIT] = s_q.idle_flag;
					end
					wwd_pkg::ADDR_STATUS: begin
						s_d.rdata = {29'h00000000, s_q.status};
						status_rd = 1'b1;
					end
					wwd_pkg::ADDR_MASK: s_d.rdata = {29'h00000000, s_q.mask};
					default: s_d.rdata = 32'h0000_0000;
				endcase
			end
		end
		// A read clears what it saw; an event in the same cycle still sets its bit.
		s_d.status = (status_rd ? {wwd_pkg::EV_W{1'b0}} : s_q.status) | ev_set;
		if (clr_counts) begin
			s_d.low_power_rc_clock_cnt = 10'h000;
			s_d.pre_cnt = 7'h00;
			s_d.post_cnt = 15'h0000;
		end
		if (s_q.mode == wwd_pkg::WWD_WAKE && !power_save_instr) begin
			s_d.mode = wwd_pkg::WWD_RUN;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			s_q <= '0;
			s_q.ctrl <= wwd_pkg::CTRL_RESET;
			s_q.soft_en <= 1'b0;
			s_q.mode <= wwd_pkg::WWD_RUN;
		end else begin
			s_q <= s_d;
		end
	end

	assign wb_dat_o = s_q.rdata;
	assign wb_ack_o = s_q.ack;
	assign low_power_rc_clock_en = s_q.ctrl[wwd_pkg::CTRL_CFGEN_BIT] || s_q.soft_en;
	assign watchdog_reset = s_q.wdt_reset;
	assign watchdog_wake = s_q.wake;
	assign irq = |(s_q.status & s_q.mask);
endmodule

// ===== sim/wwd_checker.sv
// Assertion checker for the windowed watchdog, bound to its top module.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
module wwd_checker (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic watchdog_clear_instr,
	input wire logic power_save_instr,
	input wire logic power_save_exit,
	input wire logic clock_switch_done,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic low_power_rc_clock_en,
	input wire logic watchdog_reset,
	input wire logic watchdog_wake,
	input wire logic irq
);
	// A time-out comes more than 19000 clocks after any count clear, somewhat under one period at the reset setting.
	logic [15:0] age_q;
	logic save_q;
	always_ff @(posedge sys_clk) begin
		if (!reset_n || watchdog_clear_instr || power_save_instr || power_save_exit ||
			clock_switch_done) begin
			age_q <= 16'h0000;
		end else if (age_q != 16'hffff) begin
			age_q <= age_q + 16'h0001;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!reset_n || power_save_exit) begin
			save_q <= 1'b0;
		end else if (power_save_instr) begin
			save_q <= 1'b1;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	property p_ack_due; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack_due: assert property (p_ack_due) else $error("bus request not answered");
	property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
	property p_reset_age; watchdog_reset && !$past(watchdog_clear_instr) |-> age_q > 16'h4a38; endproperty
	a_reset_age: assert property (p_reset_age) else $error("time-out too early");
	property p_wake_age; watchdog_wake |-> age_q > 16'h4a38; endproperty
	a_wake_age: assert property (p_wake_age) else $error("wake too early");
	property p_wake_save; watchdog_wake |-> save_q && !watchdog_reset; endproperty
	a_wake_save: assert property (p_wake_save) else $error("wake outside power save");
	property p_run_reset; watchdog_reset |-> !save_q; endproperty
	a_run_reset: assert property (p_run_reset) else $error("reset during power save");
	property p_wake_clk; watchdog_wake |-> $past(low_power_rc_clock_en); endproperty
	a_wake_clk: assert property (p_wake_clk) else $error("wake with slow clock off");
	property p_irq_fall; $fell(irq) |-> wb_ack_o || $past(wb_ack_o); endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell without access");
	c_wake: cover property (watchdog_wake);
	c_reset: cover property (watchdog_reset);
	c_irq: cover property (irq);
endmodule
bind wwd_watchdog wwd_checker chk_u (.sys_clk, .reset_n, .watchdog_clear_instr,
	.power_save_instr, .power_save_exit, .clock_switch_done, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .low_power_rc_clock_en, .watchdog_reset, .watchdog_wake, .irq);

// ===== sim/tb.sv
// Self-checking bench for the windowed watchdog.
// Assumes a one-cycle bus answer and a period of 19968 clocks at the reset setting.
`timescale 1ns/1ps
module tb;
	logic sys_clk, reset_n, cyc, we, idle, ack, wk, rs, lp, irq;
	logic [3:0] ev, adr;
	logic [31:0] wd, rd, rv;
	int n_fail, samples_checked, n;
	wwd_watchdog dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .watchdog_clear_instr(ev[0]),
		.power_save_instr(ev[1]), .power_save_idle(idle), .power_save_exit(ev[2]),
		.clock_switch_done(ev[3]), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
		.low_power_rc_clock_en(lp), .watchdog_reset(rs), .watchdog_wake(wk), .irq(irq));
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task results;
		if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task over;
		n_fail++;
		results;
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		@(posedge sys_clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		rv = rd;
		cyc <= 1'b0;
		if (k >= 20) over;
	endtask
	task rdchk(input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rv, exp);
	endtask
	task pulse(input logic [3:0] m);
		@(posedge sys_clk);
		ev <= m;
		@(posedge sys_clk);
		ev <= 4'h0;
	endtask
	// Waits for either watchdog output; the count starts at the edge that took the event.
	task wt;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (rs !== 1'b1 && wk !== 1'b1 && n < 25000);
		if (n >= 25000) over;
	endtask
	task base;
		rdchk(4'h0, 32'h40);
		rdchk(4'h4, 32'h0);
		rdchk(4'h2, 32'h0);
		chk(lp, 1'b0);
	endtask
	task timed;
		bus(1'b1, 4'hc, 32'h7);
		bus(1'b1, 4'h4, 32'h20);
		repeat (3000) @(posedge sys_clk);
		chk(lp, 1'b1);
		pulse(4'h1);
		repeat (3000) @(posedge sys_clk);
		pulse(4'h8);
		wt;
		chk(n >= 19300 && n <= 20000, 1'b1);
		chk({wk, rs}, 2'b01);
		chk(irq, 1'b1);
		rdchk(4'h8, 32'h1);
		@(posedge sys_clk);
		chk(irq, 1'b0);
		rdchk(4'h4, 32'h30);
	endtask
	task window;
		bus(1'b1, 4'h0, 32'h0);
		pulse(4'h1);
		wt;
		chk(n, 1);
		chk({wk, rs}, 2'b01);
		rdchk(4'h8, 32'h2);
		repeat (16000) @(posedge sys_clk);
		pulse(4'h1);
		@(posedge sys_clk);
		chk({wk, rs}, 2'b00);
		rdchk(4'h8, 32'h0);
		bus(1'b1, 4'h0, 32'h40);
	endtask
	task nap;
		bus(1'b1, 4'h4, 32'h20);
		rdchk(4'h4, 32'h20);
		pulse(4'h2);
		wt;
		chk(n >= 19300 && n <= 20000, 1'b1);
		chk({wk, rs}, 2'b10);
		rdchk(4'h4, 32'h28);
		pulse(4'h4);
		bus(1'b1, 4'h4, 32'h20);
		idle <= 1'b1;
		pulse(4'h2);
		rdchk(4'h4, 32'h24);
		pulse(4'h4);
	endtask
	task forced;
		bus(1'b1, 4'h4, 32'h0);
		bus(1'b1, 4'h0, 32'hc0);
		@(posedge sys_clk);
		chk(lp, 1'b1);
		reset_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		rdchk(4'h0, 32'h40);
		rdchk(4'h4, 32'h0);
		chk(lp, 1'b0);
	endtask
	initial begin
		reset_n = 1'b0;
		cyc = 1'b0;
		we = 1'b0;
		idle = 1'b0;
		ev = 4'h0;
		adr = 4'h0;
		wd = 32'h0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		base;
		timed;
		window;
		nap;
		forced;
		results;
	end
endmodule
